// File: ftc_core.v
/*
 * function timer core: one up-counter shared by timer, capture, aligned
 * pwm and complementary pwm modes, registers over axi4-lite.
 * assumes: trigger inputs synchronous to aclk, one clock domain.
 */
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "ftc_defs.vh"

module ftc_core #(
  parameter integer CW       = 16,
  parameter integer NTRIG    = 16,
  parameter integer DIV_W    = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [7:0]        s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [7:0]        s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire [NTRIG-1:0]  trig_in,
  output reg               out_pos,
  output reg               out_neg,
  output reg               trig_out,
  output reg               irq
);

  ////////////////////////////////////////////////////////////////////////////
  reg [31:0]   mode_reg;
  reg [31:0]   clock_sel_reg;
  reg [31:0]   trigger_cfg0;
  reg [31:0]   trigger_cfg1;
  reg [15:0]   irq_enable_reg;
  reg [15:0]   irq_status_reg;
  reg [CW-1:0] period_reg;
  reg [CW-1:0] event_reg_a;
  reg [CW-1:0] event_reg_b;
  reg [CW-1:0] dead_time_reg;
  reg [CW-1:0] period_act_r;
  reg [CW-1:0] eva_act_r;
  reg [CW-1:0] evb_act_r;
  reg [CW-1:0] dead_act_r;
  reg          run_bit;
  reg          trigger_enable;
  reg          output_shutdown;
  reg          update_request;
  reg          running_status;
  reg [CW-1:0] counter_reg;
  reg          start_pend_r;
  reg          arm_r;
  reg [DIV_W-1:0] div_cnt_r;
  reg          count_clk;
  reg          trig_d_r;
  reg          pos_r;
  reg          neg_r;
  reg [CW-1:0] dead_cnt_r;
  reg          first_r;

  wire [1:0]   op_mode_sel  = mode_reg[`FTC_MODE_LSB+1:`FTC_MODE_LSB];
  wire         one_shot_sel = mode_reg[`FTC_OST_BIT];
  wire         period_irq_en = irq_enable_reg[`FTC_IRQ_P];

  function is_addr;
    input [7:0] a;
    input [7:0] off;
    begin
      is_addr = (a[7:2] == off[7:2]);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // count clock: divided aclk; falling edge is the tick
  wire [DIV_W-1:0] div_max = clock_sel_reg[DIV_W-1:0];
  wire tick = count_clk && (div_cnt_r == div_max);

  always @(posedge aclk) begin
    if (!aresetn) begin
      div_cnt_r <= {DIV_W{1'b0}};
      count_clk <= 1'b0;
    end else if (div_cnt_r == div_max) begin
      div_cnt_r <= {DIV_W{1'b0}};
      count_clk <= ~count_clk;
    end else begin
      div_cnt_r <= div_cnt_r + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // event trigger select and edges
  wire tsel  = trig_in[trigger_cfg0[`FTC_TSRC_LSB+3:`FTC_TSRC_LSB]];
  wire t_ris = tsel & ~trig_d_r;
  wire t_fal = ~tsel & trig_d_r;
  wire t_start = trigger_enable && trigger_cfg0[`FTC_TSTART_BIT] && t_ris
                 && !running_status;
  wire t_stop  = trigger_enable && trigger_cfg0[`FTC_TSTOP_BIT] && t_ris
                 && running_status;

  wire at_top   = (counter_reg == period_act_r);
  wire counting = running_status && arm_r;
  wire ovf      = tick && counting && at_top;
  wire os_stop  = ovf && one_shot_sel && period_irq_en;
  wire cmp_a    = tick && counting && (counter_reg == eva_act_r);
  wire cmp_b    = tick && counting && (counter_reg == evb_act_r);
  wire cap_mode = (op_mode_sel == `FTC_MODE_CAPTURE);

  ////////////////////////////////////////////////////////////////////////////
  // axi4-lite slave
  wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid
               && !s_axi_awready;
  wire rd_go = s_axi_arvalid && !s_axi_rvalid && !s_axi_arready;
  wire [7:0] wa = s_axi_awaddr;
  wire [31:0] wd = s_axi_wdata;
  wire wr_ctrl0  = wr_go && is_addr(wa, `FTC_OFF_CTRL0);
  wire wr_clr    = wr_go && is_addr(wa, `FTC_OFF_IRQCLR);
  wire wr_count  = wr_go && is_addr(wa, `FTC_OFF_COUNT);
  wire wr_ctrl1  = wr_go && is_addr(wa, `FTC_OFF_CTRL1);
  wire wmap = is_addr(wa, `FTC_OFF_MODE) || is_addr(wa, `FTC_OFF_CLKSEL) ||
              is_addr(wa, `FTC_OFF_TRG0) || is_addr(wa, `FTC_OFF_TRG1) ||
              is_addr(wa, `FTC_OFF_IRQEN) || is_addr(wa, `FTC_OFF_PERIOD) ||
              is_addr(wa, `FTC_OFF_EVA) || is_addr(wa, `FTC_OFF_EVB) ||
              is_addr(wa, `FTC_OFF_DEAD) || is_addr(wa, `FTC_OFF_CTRL0) ||
              is_addr(wa, `FTC_OFF_CTRL1) || is_addr(wa, `FTC_OFF_COUNT) ||
              is_addr(wa, `FTC_OFF_IRQSTAT) || is_addr(wa, `FTC_OFF_IRQCLR);

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `FTC_RESP_OKAY;
    end else begin
      s_axi_awready <= wr_go;
      s_axi_wready  <= wr_go;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wmap ? `FTC_RESP_OKAY : `FTC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  reg [31:0] rd_mux;
  reg        rd_ok;
  always @* begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr[7:2])
      6'h00: rd_mux = mode_reg;
      6'h01: rd_mux = clock_sel_reg;
      6'h02: rd_mux = trigger_cfg0;
      6'h03: rd_mux = trigger_cfg1;
      6'h04: rd_mux = {16'h0000, irq_enable_reg};
      6'h05: rd_mux = {{(32-CW){1'b0}}, period_reg};
      6'h06: rd_mux = {{(32-CW){1'b0}}, event_reg_a};
      6'h07: rd_mux = {{(32-CW){1'b0}}, event_reg_b};
      6'h08: rd_mux = {{(32-CW){1'b0}}, dead_time_reg};
      6'h09: rd_mux = {29'h0, output_shutdown, trigger_enable, run_bit};
      6'h0a: rd_mux = {30'h0, update_request, running_status};
      6'h0b: rd_mux = {{(32-CW){1'b0}}, counter_reg};
      6'h0c: rd_mux = {16'h0000, irq_status_reg};
      6'h0d: rd_mux = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `FTC_RESP_OKAY;
    end else begin
      s_axi_arready <= rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_mux;
        s_axi_rresp  <= rd_ok ? `FTC_RESP_OKAY : `FTC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg        <= 32'h0000_0000;
      clock_sel_reg   <= 32'h0000_0000;
      trigger_cfg0    <= 32'h0000_0000;
      trigger_cfg1    <= 32'h0000_0000;
      irq_enable_reg  <= 16'h0000;
      period_reg      <= `FTC_PERIOD_RST;
      event_reg_a     <= {CW{1'b0}};
      event_reg_b     <= {CW{1'b0}};
      dead_time_reg   <= {CW{1'b0}};
      trigger_enable  <= 1'b0;
      output_shutdown <= 1'b0;
    end else begin
      if (wr_go && is_addr(wa, `FTC_OFF_MODE))   mode_reg <= wd;
      if (wr_go && is_addr(wa, `FTC_OFF_CLKSEL)) clock_sel_reg <= wd;
      if (wr_go && is_addr(wa, `FTC_OFF_TRG0))   trigger_cfg0 <= wd;
      if (wr_go && is_addr(wa, `FTC_OFF_TRG1))   trigger_cfg1 <= wd;
      if (wr_go && is_addr(wa, `FTC_OFF_IRQEN))  irq_enable_reg <= wd[15:0];
      if (wr_go && is_addr(wa, `FTC_OFF_PERIOD) && wd[CW-1:0] != {CW{1'b0}})
        period_reg <= wd[CW-1:0];
      if (wr_go && is_addr(wa, `FTC_OFF_EVB)) event_reg_b <= wd[CW-1:0];
      if (wr_go && is_addr(wa, `FTC_OFF_DEAD)) dead_time_reg <= wd[CW-1:0];
      if (cap_mode && counting && trigger_enable && t_ris)
        event_reg_a <= counter_reg;
      else if (wr_go && is_addr(wa, `FTC_OFF_EVA))
        event_reg_a <= wd[CW-1:0];
      if (cap_mode && counting && trigger_enable && t_fal)
        event_reg_b <= counter_reg;
      if (wr_ctrl0) begin
        trigger_enable  <= wd[`FTC_GTEN_BIT];
        output_shutdown <= wd[`FTC_SDN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run control and counter
  always @(posedge aclk) begin
    if (!aresetn) begin
      run_bit        <= 1'b0;
      running_status <= 1'b0;
      start_pend_r   <= 1'b0;
      arm_r          <= 1'b0;
      counter_reg    <= {CW{1'b0}};
      update_request <= 1'b0;
      period_act_r   <= `FTC_PERIOD_RST;
      eva_act_r      <= {CW{1'b0}};
      evb_act_r      <= {CW{1'b0}};
      dead_act_r     <= {CW{1'b0}};
      trig_d_r       <= 1'b0;
    end else begin
      trig_d_r <= tsel;
      if (os_stop)
        run_bit <= 1'b0;
      else if (wr_ctrl0)
        run_bit <= wd[`FTC_RUN_BIT];
      else if (t_start)
        run_bit <= 1'b1;
      else if (t_stop)
        run_bit <= 1'b0;
      if (wr_ctrl1 && wd[`FTC_UD_BIT])
        update_request <= 1'b1;
      if (tick) begin
        if (run_bit && !running_status && !os_stop) begin
          running_status <= 1'b1;
          arm_r          <= 1'b0;
        end else if ((!run_bit || os_stop) && running_status) begin
          running_status <= 1'b0;
          arm_r          <= 1'b0;
        end else if (running_status) begin
          arm_r <= 1'b1;
        end
        if (counting) begin
          if (at_top) begin
            counter_reg <= {CW{1'b0}};
            if (update_request && !(wr_ctrl1 && wd[`FTC_UD_BIT])) begin
              period_act_r   <= period_reg;
              eva_act_r      <= event_reg_a;
              evb_act_r      <= event_reg_b;
              dead_act_r     <= dead_time_reg;
              update_request <= 1'b0;
            end
          end else begin
            counter_reg <= counter_reg + 1'b1;
          end
        end
      end
      if (wr_count && !running_status)
        counter_reg <= {CW{1'b0}};
      if (!running_status && !start_pend_r && !update_request) begin
        period_act_r <= period_reg;
        eva_act_r    <= event_reg_a;
        evb_act_r    <= event_reg_b;
        dead_act_r   <= dead_time_reg;
      end
      start_pend_r <= run_bit && !running_status;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // waveform generation and dead time
  wire dead_done = (dead_cnt_r >= dead_act_r) || cap_mode;
  always @(posedge aclk) begin
    if (!aresetn) begin
      pos_r      <= 1'b0;
      neg_r      <= 1'b1;
      dead_cnt_r <= {CW{1'b0}};
      first_r    <= 1'b1;
    end else if (!running_status) begin
      dead_cnt_r <= {CW{1'b0}};
      first_r    <= 1'b1;
      if (counter_reg == {CW{1'b0}} || os_stop) begin
        pos_r <= 1'b0;
        neg_r <= (op_mode_sel == `FTC_MODE_TIMER) && !one_shot_sel;
      end
    end else if (tick && counting) begin
      if (!dead_done)
        dead_cnt_r <= dead_cnt_r + 1'b1;
      if (counter_reg == {CW{1'b0}})
        first_r <= 1'b0;
      case (op_mode_sel)
        `FTC_MODE_TIMER: begin
          if (counter_reg == {CW{1'b0}} && first_r) begin
            pos_r <= one_shot_sel;
            neg_r <= ~one_shot_sel;
          end else if (ovf) begin
            pos_r <= one_shot_sel ? 1'b0 : ~pos_r;
            neg_r <= one_shot_sel ? 1'b0 : ~neg_r;
          end
        end
        `FTC_MODE_PWM1: begin
          pos_r <= (counter_reg < eva_act_r) && !os_stop;
          neg_r <= (counter_reg < evb_act_r) && !os_stop;
        end
        `FTC_MODE_PWM2: begin
          pos_r <= (counter_reg < eva_act_r) && !os_stop;
          neg_r <= !(counter_reg < eva_act_r) && !os_stop;
        end
        default: begin
          pos_r <= 1'b0;
          neg_r <= 1'b0;
        end
      endcase
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      out_pos  <= 1'b0;
      out_neg  <= 1'b0;
      trig_out <= 1'b0;
    end else begin
      out_pos  <= pos_r && dead_done && !output_shutdown;
      out_neg  <= neg_r && dead_done && !output_shutdown;
      trig_out <= ovf;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags; set wins over clear
  wire [15:0] ev_set = {11'h000, t_start, t_stop,
                        cmp_b && (op_mode_sel != `FTC_MODE_CAPTURE),
                        cmp_a && (op_mode_sel != `FTC_MODE_CAPTURE),
                        ovf};
  wire [15:0] clr = wr_clr ? (wd[15:0] & 16'h7fff) : 16'h0000;
  wire        pend = |(irq_status_reg & irq_enable_reg);
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 16'h0000;
      irq            <= 1'b0;
    end else begin
      irq_status_reg <= (irq_status_reg & ~clr) | ev_set;
      if (|(ev_set & irq_enable_reg))
        irq <= 1'b1;
      else if (wr_clr && wd[`FTC_IRQ_RR])
        irq <= |(irq_status_reg & ~clr & irq_enable_reg);
      else if (!pend)
        irq <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// File: ftc_defs.vh
/*
 * register offsets, field positions, reset values and encodings of the
 * function timer core.
 * assumes: included by the core, its monitor and the bench, byte addresses on axi4-lite.
 */
`ifndef FTC_DEFS_VH
`define FTC_DEFS_VH

`define FTC_OFF_MODE      8'h00
`define FTC_OFF_CLKSEL    8'h04
`define FTC_OFF_TRG0      8'h08
`define FTC_OFF_TRG1      8'h0c
`define FTC_OFF_IRQEN     8'h10
`define FTC_OFF_PERIOD    8'h14
`define FTC_OFF_EVA       8'h18
`define FTC_OFF_EVB       8'h1c
`define FTC_OFF_DEAD      8'h20
`define FTC_OFF_CTRL0     8'h24
`define FTC_OFF_CTRL1     8'h28
`define FTC_OFF_COUNT     8'h2c
`define FTC_OFF_IRQSTAT   8'h30
`define FTC_OFF_IRQCLR    8'h34

// mode register fields
`define FTC_MODE_LSB      0
`define FTC_OST_BIT       4
`define FTC_MODE_TIMER    2'h0
`define FTC_MODE_CAPTURE  2'h1
`define FTC_MODE_PWM1     2'h2
`define FTC_MODE_PWM2     2'h3

// ctrl0 fields
`define FTC_RUN_BIT       0
`define FTC_GTEN_BIT      1
`define FTC_SDN_BIT       2
// ctrl1 fields
`define FTC_STAT_BIT      0
`define FTC_UD_BIT        1
// trigger cfg0 fields
`define FTC_TSRC_LSB      0
`define FTC_TSTART_BIT    8
`define FTC_TSTOP_BIT     9
// irq bits
`define FTC_IRQ_P         0
`define FTC_IRQ_A         1
`define FTC_IRQ_B         2
`define FTC_IRQ_TS        3
`define FTC_IRQ_TR        4
`define FTC_IRQ_RR        15

`define FTC_PERIOD_RST    16'hffff
`define FTC_RESP_OKAY     2'h0
`define FTC_RESP_SLVERR   2'h2

`endif

// File: ftc_core_monitor.sv
/*
 * port checker for ftc_core: bus answers, reset quiet, overflow spacing.
 * assumes: bound onto ftc_core from the bench top, one clock aclk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftc_defs.vh"
module ftc_core_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        out_pos,
  input wire logic        out_neg,
  input wire logic        trig_out,
  input wire logic        irq
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////
  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  endsequence
  property p_rst_quiet;
    $rose(aresetn) |-> !(out_pos || out_neg || irq || trig_out || s_axi_bvalid || s_axi_rvalid);
  endproperty
  property p_wr_ans;
    s_wr_take |=> s_axi_bvalid && s_axi_awready && s_axi_wready;
  endproperty
  property p_rd_ans;
    s_rd_take |=> s_axi_rvalid && s_axi_arready;
  endproperty
  property p_clr_zero;
    s_rd_take ##0 (s_axi_araddr == `FTC_OFF_IRQCLR) |=> s_axi_rvalid && s_axi_rdata == 32'h0;
  endproperty
  property p_bad_rd;
    s_rd_take ##0 (s_axi_araddr >= 8'h38) |=> s_axi_rresp == `FTC_RESP_SLVERR;
  endproperty
  property p_b_stands;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_stands;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
  endproperty
  // period of at least two ticks, tick at least two clocks
  property p_ovf_gap;
    trig_out |=> !trig_out [*3];
  endproperty
  ////////////////////////////////////////////////////////////
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs busy after reset");
  a_wr_ans: assert property (p_wr_ans)
    else $error("write not answered");
  a_rd_ans: assert property (p_rd_ans)
    else $error("read not answered");
  a_clr_zero: assert property (p_clr_zero)
    else $error("clear register read not zero");
  a_bad_rd: assert property (p_bad_rd)
    else $error("unmapped read not refused");
  a_b_stands: assert property (p_b_stands)
    else $error("write response dropped");
  a_r_stands: assert property (p_r_stands)
    else $error("read response dropped");
  a_ovf_gap: assert property (p_ovf_gap)
    else $error("overflow pulses too close");
endmodule
`default_nettype wire

// File: ftc_trig_src.sv
/*
 * trigger source model: one selected level line, the rest random noise.
 * assumes: levels synchronous to aclk, lag in clocks before a change shows.
 */
`timescale 1ns/1ps
`default_nettype none
module ftc_trig_src (
  input wire logic        aclk,
  input wire logic [3:0]  sel,
  input wire logic        level,
  input wire logic [3:0]  lag,
  output logic     [15:0] trig_in
);
  logic   [15:0] noise = 16'h0;
  logic   [3:0]  cnt   = 4'h0;
  logic          held  = 1'b0;
  integer        seed  = 32'h1019;
  always @(posedge aclk) begin
    noise <= $random(seed);
    if (level == held) cnt <= 4'h0;
    else if (cnt >= lag) begin
      held <= level;
      cnt  <= 4'h0;
    end
    else cnt <= cnt + 4'h1;
  end
  // unselected lines keep changing
  always_comb begin
    trig_in      = noise;
    trig_in[sel] = held;
  end
endmodule
`default_nettype wire

// File: ftc_core_tb.sv
/*
 * self-checking bench for ftc_core over axi4-lite with a trigger source.
 * assumes: clock divider 0, so one count tick every two clocks.
 */
`timescale 1ns/1ps
`default_nettype none
`include "ftc_defs.vh"
module ftc_core_tb;
  localparam integer TK = 2;
  logic        aclk;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb = 4'hf, sel = 4'h0, lag = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, level = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [15:0] trig_in;
  logic        out_pos, out_neg, trig_out, irq, d;
  integer      fail_count = 0, compares = 0, seed = 32'h1019, stall = 0, i, p, t;

  ftc_core dut (.*);
  ftc_trig_src u_src (.*);

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////
  task end_of_test;
    begin
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    begin
      compares++;
      if (g !== e) begin
        fail_count++;
        $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] v);
    integer k;
    begin
      @(posedge aclk);
      stall = $unsigned($random(seed)) % 3;
      if (w) begin
        s_axi_awaddr  <= a;
        s_axi_wdata   <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
      end
      else begin
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
      end
      k = 0;
      forever begin
        @(posedge aclk);
        k++;
        if ((w ? s_axi_bvalid && s_axi_bready : s_axi_rvalid && s_axi_rready) || k > 60) break;
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (k >= stall && w) s_axi_bready <= 1'b1;
        if (k >= stall && !w) s_axi_rready <= 1'b1;
      end
      rd = s_axi_rdata;
      rs = w ? s_axi_bresp : s_axi_rresp;
      if (k > 60) chk("bus answer", 0, 1);
      s_axi_awvalid <= 1'b0;
      s_axi_wvalid  <= 1'b0;
      s_axi_arvalid <= 1'b0;
      s_axi_bready  <= 1'b0;
      s_axi_rready  <= 1'b0;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    acc(1'b1, a, v);
  endtask
  task rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    begin
      acc(1'b0, a, 32'h0);
      chk(nm, e, rd);
    end
  endtask
  // clocks until the next overflow pulse
  task ovf;
    begin
      t = 0;
      do begin
        @(posedge aclk);
        t++;
      end while (trig_out !== 1'b1 && t < 2000);
      if (trig_out !== 1'b1) chk("overflow seen", 1, 0);
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rdc("ctrl0", `FTC_OFF_CTRL0, 0);
    rdc("ctrl1", `FTC_OFF_CTRL1, 0);
    rdc("count", `FTC_OFF_COUNT, 0);
    rdc("period", `FTC_OFF_PERIOD, 32'hffff);
    rdc("clear reg", `FTC_OFF_IRQCLR, 0);
    acc(1'b0, 8'h3c, 32'h0);
    chk("bad addr", `FTC_RESP_SLVERR, rs);
    for (i = 3; i >= 0; i--) begin
      wr(`FTC_OFF_MODE, i);
      rdc("mode", `FTC_OFF_MODE, i);
    end
    wr(`FTC_OFF_CLKSEL, 0);
    wr(`FTC_OFF_IRQEN, 1);
    for (i = 0; i < 3; i++) begin
      p = 1 + $unsigned($random(seed)) % 8;
      wr(`FTC_OFF_PERIOD, p);
      wr(`FTC_OFF_CTRL0, 1);
      ovf;
      ovf;
      chk("period gap", (p + 1) * TK, t);
      wr(`FTC_OFF_CTRL0, 0);
      acc(1'b0, `FTC_OFF_COUNT, 32'h0);
      p = rd;
      rdc("held count", `FTC_OFF_COUNT, p);
      rdc("status", `FTC_OFF_CTRL1, 0);
      wr(`FTC_OFF_COUNT, $random(seed));
      rdc("cleared", `FTC_OFF_COUNT, 0);
    end
    wr(`FTC_OFF_PERIOD, 3);
    wr(`FTC_OFF_CTRL0, 1);
    ovf;
    wr(`FTC_OFF_PERIOD, 6);
    ovf;
    ovf;
    chk("no update", 4 * TK, t);
    wr(`FTC_OFF_CTRL1, 2);
    ovf;
    ovf;
    ovf;
    chk("updated", 7 * TK, t);
    repeat (3) @(posedge aclk);
    d = out_pos;
    chk("timer pair", 1, out_pos ^ out_neg);
    ovf;
    repeat (3) @(posedge aclk);
    chk("toggle", !d, out_pos);
    wr(`FTC_OFF_CTRL0, 5);
    repeat (20) begin
      @(posedge aclk);
      chk("shutdown", 0, out_pos | out_neg);
    end
    wr(`FTC_OFF_CTRL0, 0);
    wr(`FTC_OFF_MODE, `FTC_MODE_PWM2);
    wr(`FTC_OFF_EVA, 2);
    wr(`FTC_OFF_CTRL0, 1);
    ovf;
    repeat (12) begin
      @(posedge aclk);
      chk("complement", 1, out_pos ^ out_neg);
    end
    wr(`FTC_OFF_CTRL0, 0);
    wr(`FTC_OFF_MODE, `FTC_MODE_PWM1);
    wr(`FTC_OFF_EVA, 7);
    wr(`FTC_OFF_DEAD, 4);
    wr(`FTC_OFF_CTRL0, 1);
    repeat (2) @(posedge aclk);
    chk("dead time", 0, out_pos);
    ovf;
    ovf;
    repeat (12) begin
      @(posedge aclk);
      chk("aligned pwm", 2, {out_pos, out_neg});
    end
    wr(`FTC_OFF_CTRL0, 0);
    wr(`FTC_OFF_COUNT, 0);
    wr(`FTC_OFF_MODE, 32'h10);
    wr(`FTC_OFF_PERIOD, 2);
    wr(`FTC_OFF_EVA, 1);
    wr(`FTC_OFF_EVB, 5);
    wr(`FTC_OFF_IRQCLR, 32'h1f);
    wr(`FTC_OFF_CTRL0, 1);
    ovf;
    repeat (8) @(posedge aclk);
    rdc("one shot run", `FTC_OFF_CTRL0, 0);
    rdc("one shot count", `FTC_OFF_COUNT, 0);
    acc(1'b0, `FTC_OFF_IRQSTAT, 32'h0);
    chk("period flag", 1, rd[0]);
    chk("compare flags", 2'b01, rd[2:1]);
    chk("irq", 1, irq);
    wr(`FTC_OFF_IRQCLR, 32'h803f);
    rdc("flags clear", `FTC_OFF_IRQSTAT, 0);
    chk("irq low", 0, irq);
    wr(`FTC_OFF_MODE, `FTC_MODE_CAPTURE);
    wr(`FTC_OFF_PERIOD, 32'hffff);
    i = $random(seed);
    sel <= i[3:0];
    lag <= i[7:4] % 8;
    wr(`FTC_OFF_TRG0, 32'h300 | i[3:0]);
    wr(`FTC_OFF_CTRL0, 2);
    repeat (10) @(posedge aclk);
    acc(1'b0, `FTC_OFF_CTRL1, 32'h0);
    chk("noise ignored", 0, rd[0]);
    level <= 1'b1;
    repeat (40) @(posedge aclk);
    acc(1'b0, `FTC_OFF_CTRL1, 32'h0);
    chk("trig start", 1, rd[0]);
    level <= 1'b0;
    repeat (30) @(posedge aclk);
    level <= 1'b1;
    repeat (40) @(posedge aclk);
    acc(1'b0, `FTC_OFF_CTRL1, 32'h0);
    chk("trig stop", 0, rd[0]);
    acc(1'b0, `FTC_OFF_IRQSTAT, 32'h0);
    chk("trig flags", 3, rd[4:3]);
    acc(1'b0, `FTC_OFF_EVB, 32'h0);
    p = rd;
    acc(1'b0, `FTC_OFF_EVA, 32'h0);
    chk("capture b", 1, p > 0);
    chk("capture a", 1, rd > p);
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    fail_count++;
    end_of_test;
  end
endmodule
bind ftc_core ftc_core_monitor u_mon (.*);
`default_nettype wire
